// [core/ccs_pkg.sv]
// Register map, field layout and shared types of the calibration scheduler
`default_nettype none
package ccs_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_CLOCK_POWER_CONFIG    = 8'hC5;
	localparam logic [7:0]  IDX_FRONTEND_RATE_CONFIG  = 8'hC9;
	localparam logic [7:0]  IDX_AMPLITUDE_MEAS_CONFIG = 8'hCB;
	localparam logic [7:0]  IDX_ZERO_CROSS_LEVEL      = 8'hD0;
	localparam logic [7:0]  IDX_FAST_CLOCK_CAL_VALUE  = 8'hE4;
	localparam logic [7:0]  IDX_CAL_STATUS            = 8'hE5;

	// Field positions
	localparam int          RATE_W          = 3;
	localparam int          FAST_RATE_LSB   = 0;
	localparam int          ZCC_RATE_LSB    = 0;
	localparam int          AMPLITUDE_RATE_LSB     = 0;
	localparam int          STOP_WAVE_LSB   = 4;
	localparam int          STOP_WAVE_W     = 5;
	localparam int          AMPLITUDE_CAL_RATE_LSB    = 12;
	localparam int          ZCL_W           = 8;
	localparam int          STAT_UPD_BIT    = 0;
	localparam int          STAT_BUSY_BIT   = 1;
	localparam int          CNT_W           = 7;
	localparam int          NUM_TASKS       = 7;

	// Reset values
	localparam logic [31:0] CPC_RESET       = 32'h0000_0000;
	localparam logic [31:0] FRC_RESET       = 32'h0000_0000;
	localparam logic [31:0] AMC_CFG_RESET   = 32'h0000_0000;
	localparam logic [7:0]  ZCL_RESET       = 8'h00;

	// Front-end RAM cells for amplitude results
	localparam logic [8:0]  RAM_AMP_UP      = 9'h082;
	localparam logic [8:0]  RAM_CAL_HIGH    = 9'h083;
	localparam logic [8:0]  RAM_AMP_DN      = 9'h086;
	localparam logic [8:0]  RAM_CAL_LOW     = 9'h087;

	// Measurement constants
	localparam logic [2:0]  SLOW_PERIODS    = 3'h4;
	localparam logic [4:0]  PEAK_START_WAVE = 5'h01;

	// Rate field code to number of events between runs
	localparam logic [CNT_W-1:0] RATE_TABLE [8] = '{7'h00, 7'h01, 7'h02, 7'h05,
		7'h0A, 7'h14, 7'h32, 7'h64};

	// Converter tasks in run order within one sequence cycle
	typedef enum logic [2:0] {
		TK_OFFSET, TK_FAST_CAL, TK_AMP_UP, TK_AMP_DN, TK_REF_HIGH, TK_REF_HALF, TK_FLOW, TK_NONE
	} ccs_task_e;

	typedef enum logic [2:0] {S_IDLE, S_PICK, S_GATE, S_HOLD, S_CONV, S_DONE} ccs_state_e;

	// Raw converter value: whole fast periods and fraction
	typedef struct packed {
		logic [15:0] whole;
		logic [15:0] frac;
	} ccs_raw_s;

	// Front-end RAM write
	typedef struct packed {
		logic        we;
		logic [8:0]  addr;
		ccs_raw_s    data;
	} ccs_ram_wr_s;
endpackage : ccs_pkg
`default_nettype wire

// [core/ccs_top.sv]
// Chip calibration scheduler with Wishbone register slave
//
// Contract
// [RQ1] Fast-oscillator calibration every N sequence triggers; N off/1/2/5/10/20/50/100.
// [RQ2] Fast calibration times four slow-oscillator periods in fast periods.
// [RQ3] Fast calibration raw result lands in the fast clock calibration value register at 0x0E4.
// [RQ4] Fast oscillator runs only during converter measurements.
// [RQ5] Firmware scales raw results by the calibration factor; hardware does not.
// [RQ6] Amplitude: hold peak, discharge at constant current, converter times discharge.
// [RQ7] Amplitude calibrated with discharges at reference level and half of it.
// [RQ8] Amplitude measurement every N sequence cycles, N off/1/2/5/10/20/50/100.
// [RQ9] Peak detection stops at configured wave 1..31; zero disables it.
// [RQ10] Amplitude reference calibration once per N amplitude measurements.
// [RQ11] Upstream amplitude to RAM 0x082, downstream to RAM 0x086.
// [RQ12] High reference result to RAM 0x083, low reference to RAM 0x087.
// [RQ13] Peak detection always starts at the first received wave.
// [RQ14] Offset calibration once after power-on, then at the configured rate.
// [RQ15] Each offset calibration overwrites the zero-cross level register.
// [RQ16] Ring oscillator calibrated at the start of every converter measurement.
// [RQ17] Raw results are 32 bits: 16 whole periods, 16 fraction bits.
// [RQ18] Update flag reads 1 after a new fast calibration value was stored.
// [RQ19] Each rated task has its own counter, restarts on run, rate zero never runs.
// [RQ20] Due calibrations run in that cycle's task list before results go out.
`default_nettype none
module ccs_top
	import ccs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        seq_trig_i,
	input  wire logic        slow_osc_i,
	input  wire logic        peak_done_i,
	input  wire logic        conv_done_i,
	input  wire ccs_raw_s    conv_result_i,
	output logic             fast_osc_en_o,
	output logic             conv_start_o,
	output logic             ring_cal_o,
	output ccs_task_e        conv_task_o,
	output logic             conv_gate_o,
	output logic             peak_hold_o,
	output logic      [4:0]  peak_start_wave_o,
	output logic      [4:0]  peak_stop_wave_o,
	output logic             discharge_o,
	output logic             ref_half_o,
	output ccs_ram_wr_s      ram_wr_o,
	output logic [ZCL_W-1:0] zero_cross_level_o,
	output logic             fast_clock_cal_updated_o,
	output logic             tasks_done_o
);

	// Merge a bus write into a register under byte enables
	function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : byte_merge

	// One event on a rated counter: {hit, next count}
	function automatic logic [CNT_W:0] rate_tick(input logic [CNT_W-1:0] cnt,
		input logic [RATE_W-1:0] code);
		logic [CNT_W-1:0] lim;
		logic [CNT_W-1:0] nxt;
		lim = RATE_TABLE[code];
		nxt = cnt + 7'h01;
		if (lim == 7'h00) begin
			return {1'b0, 7'h00};
		end else if (nxt >= lim) begin
			return {1'b1, 7'h00};
		end
		return {1'b0, nxt};
	endfunction : rate_tick

	// First pending task in run order
	function automatic ccs_task_e first_due(input logic [NUM_TASKS-1:0] due);
		ccs_task_e t;
		t = TK_NONE;
		for (int i = NUM_TASKS - 1; i >= 0; i--) begin
			if (due[i]) begin
				t = ccs_task_e'(i[2:0]);
			end
		end
		return t;
	endfunction : first_due

	logic [2:0]           sync1_reg;
	logic [2:0]           sync2_reg;
	logic                 trig_prev_reg;
	logic                 slow_prev_reg;
	logic [31:0]          cpc_reg;
	logic [31:0]          frc_reg;
	logic [31:0]          amcfg_reg;
	logic [ZCL_W-1:0]     zcl_reg;
	ccs_raw_s             fast_val_reg;
	logic                 upd_reg;
	logic                 ack_reg;
	logic [31:0]          rdat_reg;
	ccs_state_e           state_reg;
	ccs_task_e            task_reg;
	logic [NUM_TASKS-1:0] due_reg;
	logic [NUM_TASKS-1:0] due_next;
	logic                 zcc_boot_reg;
	logic [2:0]           gate_cnt_reg;
	logic [CNT_W-1:0]     hsc_cnt_reg;
	logic [CNT_W-1:0]     am_cnt_reg;
	logic [CNT_W-1:0]     amc_cnt_reg;
	logic [CNT_W-1:0]     zcc_cnt_reg;
	logic [CNT_W:0]       hsc_tick;
	logic [CNT_W:0]       am_tick;
	logic [CNT_W:0]       amc_tick;
	logic [CNT_W:0]       zcc_tick;
	logic                 fast_osc_reg;
	logic                 conv_start_reg;
	logic                 ring_cal_reg;
	logic                 gate_reg;
	logic                 hold_reg;
	logic                 disch_reg;
	logic                 half_reg;
	logic                 done_reg;
	ccs_ram_wr_s          ram_wr_reg;
	logic                 trig_edge;
	logic                 slow_edge;
	logic                 peak_done_s;
	logic                 bus_req;
	logic [7:0]           bus_idx;
	logic                 bus_hit;
	logic                 conv_end;
	logic [4:0]           stop_wave;
	logic                 am_run;
	ccs_task_e            pick;

	// Two-stage synchronisers for trigger, slow oscillator and peak detector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {peak_done_i, slow_osc_i, seq_trig_i};
			sync2_reg <= sync1_reg;
		end
	end

	// Edge history for the synchronised trigger and slow oscillator levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_prev_reg <= 1'b0;
			slow_prev_reg <= 1'b0;
		end else begin
			trig_prev_reg <= sync2_reg[0];
			slow_prev_reg <= sync2_reg[1];
		end
	end

	assign trig_edge   = sync2_reg[0] & ~trig_prev_reg;
	assign slow_edge   = sync2_reg[1] & ~slow_prev_reg;
	assign peak_done_s = sync2_reg[2];
	assign conv_end    = (state_reg == S_CONV) & conv_done_i;
	assign stop_wave   = amcfg_reg[STOP_WAVE_LSB +: STOP_WAVE_W];

	// Bus decode: word index from byte address
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign bus_idx = wb_adr_i[9:2];
	assign bus_hit = (wb_adr_i[11:10] == 2'h0);

	// Rated counters advance only on an accepted trigger
	assign hsc_tick = rate_tick(hsc_cnt_reg, cpc_reg[FAST_RATE_LSB +: RATE_W]); // [RQ1]
	assign am_tick  = rate_tick(am_cnt_reg, amcfg_reg[AMPLITUDE_RATE_LSB +: RATE_W]); // [RQ8]
	assign amc_tick = rate_tick(amc_cnt_reg, amcfg_reg[AMPLITUDE_CAL_RATE_LSB +: RATE_W]); // [RQ10]
	assign zcc_tick = rate_tick(zcc_cnt_reg, frc_reg[ZCC_RATE_LSB +: RATE_W]); // [RQ14]
	assign am_run   = trig_edge & am_tick[CNT_W] & (stop_wave != 5'h00); // [RQ9]
	assign pick     = first_due(due_reg);

	// Task list for the coming sequence cycle
	always_comb begin
		due_next                = '0;
		due_next[TK_OFFSET]     = zcc_boot_reg | (trig_edge & zcc_tick[CNT_W]); // [RQ14]
		due_next[TK_FAST_CAL]   = trig_edge & hsc_tick[CNT_W]; // [RQ1]
		due_next[TK_AMP_UP]     = am_run; // [RQ8]
		due_next[TK_AMP_DN]     = am_run;
		due_next[TK_REF_HIGH]   = am_run & amc_tick[CNT_W]; // [RQ10]
		due_next[TK_REF_HALF]   = am_run & amc_tick[CNT_W];
		due_next[TK_FLOW]       = trig_edge; // [RQ20]
	end

	// Per-task event counters, restarted when their task falls due
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hsc_cnt_reg <= '0;
			am_cnt_reg  <= '0;
			amc_cnt_reg <= '0;
			zcc_cnt_reg <= '0;
		end else if (state_reg == S_IDLE && trig_edge) begin
			hsc_cnt_reg <= hsc_tick[CNT_W-1:0]; // [RQ19]
			am_cnt_reg  <= am_tick[CNT_W-1:0]; // [RQ19]
			zcc_cnt_reg <= zcc_tick[CNT_W-1:0]; // [RQ19]
			if (am_run) begin
				amc_cnt_reg <= amc_tick[CNT_W-1:0]; // [RQ19]
			end
		end
	end

	// Sequencer: runs every due task, then hands over to firmware
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg      <= S_IDLE;
			task_reg       <= TK_NONE;
			due_reg        <= '0;
			zcc_boot_reg   <= 1'b1;
			gate_cnt_reg   <= 3'h0;
			fast_osc_reg   <= 1'b0;
			conv_start_reg <= 1'b0;
			ring_cal_reg   <= 1'b0;
			gate_reg       <= 1'b0;
			hold_reg       <= 1'b0;
			disch_reg      <= 1'b0;
			half_reg       <= 1'b0;
			done_reg       <= 1'b0;
		end else begin
			conv_start_reg <= 1'b0;
			ring_cal_reg   <= 1'b0;
			done_reg       <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (trig_edge || zcc_boot_reg) begin
						due_reg   <= due_next;
						state_reg <= S_PICK;
					end
				end
				S_PICK: begin
					if (pick == TK_NONE) begin
						state_reg <= S_DONE;
					end else begin
						task_reg      <= pick;
						due_reg[pick] <= 1'b0;
						fast_osc_reg  <= 1'b1; // [RQ4]
						gate_cnt_reg  <= 3'h0;
						if (pick == TK_OFFSET) begin
							zcc_boot_reg <= 1'b0; // [RQ14]
						end
						case (pick)
							TK_FAST_CAL: begin
								state_reg <= S_GATE;
							end
							TK_AMP_UP, TK_AMP_DN: begin
								hold_reg  <= 1'b1; // [RQ6] [RQ13]
								state_reg <= S_HOLD;
							end
							default: begin
								conv_start_reg <= 1'b1;
								ring_cal_reg   <= 1'b1; // [RQ16]
								disch_reg      <= (pick == TK_REF_HIGH) | (pick == TK_REF_HALF);
								half_reg       <= (pick == TK_REF_HALF); // [RQ7]
								state_reg      <= S_CONV;
							end
						endcase
					end
				end
				S_GATE: begin
					// Gate spans four slow periods, edge to edge
					if (slow_edge) begin
						if (gate_cnt_reg == SLOW_PERIODS) begin
							gate_reg  <= 1'b0; // [RQ2]
							state_reg <= S_CONV;
						end else begin
							gate_cnt_reg <= gate_cnt_reg + 3'h1;
							if (gate_cnt_reg == 3'h0) begin
								gate_reg       <= 1'b1; // [RQ2]
								conv_start_reg <= 1'b1;
								ring_cal_reg   <= 1'b1; // [RQ16]
							end
						end
					end
				end
				S_HOLD: begin
					// Peak held; discharge timed by the converter
					if (peak_done_s) begin
						hold_reg       <= 1'b0;
						disch_reg      <= 1'b1; // [RQ6]
						conv_start_reg <= 1'b1;
						ring_cal_reg   <= 1'b1; // [RQ16]
						state_reg      <= S_CONV;
					end
				end
				S_CONV: begin
					if (conv_done_i) begin
						fast_osc_reg <= 1'b0; // [RQ4]
						disch_reg    <= 1'b0;
						half_reg     <= 1'b0;
						state_reg    <= S_PICK;
					end
				end
				S_DONE: begin
					task_reg  <= TK_NONE;
					done_reg  <= 1'b1; // [RQ20]
					state_reg <= S_IDLE;
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// Amplitude results to front-end RAM cells
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ram_wr_reg <= '0;
		end else begin
			ram_wr_reg.we   <= 1'b0;
			ram_wr_reg.data <= conv_result_i; // [RQ17]
			if (conv_end) begin
				case (task_reg)
					TK_AMP_UP: begin
						ram_wr_reg.we   <= 1'b1;
						ram_wr_reg.addr <= RAM_AMP_UP; // [RQ11]
					end
					TK_AMP_DN: begin
						ram_wr_reg.we   <= 1'b1;
						ram_wr_reg.addr <= RAM_AMP_DN; // [RQ11]
					end
					TK_REF_HIGH: begin
						ram_wr_reg.we   <= 1'b1;
						ram_wr_reg.addr <= RAM_CAL_HIGH; // [RQ12]
					end
					TK_REF_HALF: begin
						ram_wr_reg.we   <= 1'b1;
						ram_wr_reg.addr <= RAM_CAL_LOW; // [RQ12]
					end
					default: begin
						ram_wr_reg.we <= 1'b0;
					end
				endcase
			end
		end
	end

	// Fast calibration value and its update flag; a new value beats the read clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_val_reg <= '0;
			upd_reg      <= 1'b0;
		end else if (conv_end && task_reg == TK_FAST_CAL) begin
			fast_val_reg <= conv_result_i; // [RQ3] [RQ17]
			upd_reg      <= 1'b1; // [RQ18]
		end else if (bus_req && !wb_we_i && bus_hit && bus_idx == IDX_FAST_CLOCK_CAL_VALUE) begin
			upd_reg <= 1'b0;
		end
	end

	// Zero-cross level: software may write, each offset calibration overwrites
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zcl_reg <= ZCL_RESET;
		end else if (conv_end && task_reg == TK_OFFSET) begin
			zcl_reg <= conv_result_i[ZCL_W-1:0]; // [RQ15]
		end else if (bus_req && wb_we_i && bus_hit && bus_idx == IDX_ZERO_CROSS_LEVEL
			&& wb_sel_i[0]) begin
			zcl_reg <= wb_dat_i[ZCL_W-1:0]; // Level lives in byte lane 0
		end
	end

	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpc_reg   <= CPC_RESET;
			frc_reg   <= FRC_RESET;
			amcfg_reg <= AMC_CFG_RESET;
		end else if (bus_req && wb_we_i && bus_hit) begin
			case (bus_idx)
				IDX_CLOCK_POWER_CONFIG:    cpc_reg   <= byte_merge(cpc_reg, wb_dat_i, wb_sel_i);
				IDX_FRONTEND_RATE_CONFIG:  frc_reg   <= byte_merge(frc_reg, wb_dat_i, wb_sel_i);
				IDX_AMPLITUDE_MEAS_CONFIG: amcfg_reg <= byte_merge(amcfg_reg, wb_dat_i, wb_sel_i);
				default:                   cpc_reg   <= cpc_reg;
			endcase
		end
	end

	// Bus answer: ack one cycle after the request, read data with it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg  <= bus_req;
			rdat_reg <= 32'h0000_0000;
			if (bus_req && !wb_we_i && bus_hit) begin
				case (bus_idx)
					IDX_CLOCK_POWER_CONFIG:    rdat_reg <= cpc_reg;
					IDX_FRONTEND_RATE_CONFIG:  rdat_reg <= frc_reg;
					IDX_AMPLITUDE_MEAS_CONFIG: rdat_reg <= amcfg_reg;
					IDX_ZERO_CROSS_LEVEL:      rdat_reg <= {24'h0, zcl_reg};
					IDX_FAST_CLOCK_CAL_VALUE:  rdat_reg <= fast_val_reg; // [RQ3]
					IDX_CAL_STATUS: begin
						rdat_reg[STAT_UPD_BIT]  <= upd_reg; // [RQ18]
						rdat_reg[STAT_BUSY_BIT] <= (state_reg != S_IDLE);
					end
					default:                   rdat_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Outputs straight from flip-flops
	assign wb_ack_o                 = ack_reg;
	assign wb_dat_o                 = rdat_reg;
	assign fast_osc_en_o            = fast_osc_reg;
	assign conv_start_o             = conv_start_reg;
	assign ring_cal_o               = ring_cal_reg;
	assign conv_task_o              = task_reg;
	assign conv_gate_o              = gate_reg;
	assign peak_hold_o              = hold_reg;
	assign discharge_o              = disch_reg;
	assign ref_half_o               = half_reg;
	assign ram_wr_o                 = ram_wr_reg;
	assign zero_cross_level_o       = zcl_reg;
	assign fast_clock_cal_updated_o = upd_reg;
	assign tasks_done_o             = done_reg;

	// Peak window from configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peak_start_wave_o <= PEAK_START_WAVE;
			peak_stop_wave_o  <= 5'h00;
		end else begin
			peak_start_wave_o <= PEAK_START_WAVE; // [RQ13]
			peak_stop_wave_o  <= stop_wave; // [RQ9]
		end
	end

	// Helper: slow edges seen while the calibration gate is open
	logic [2:0] gate_edges_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i || !gate_reg) begin
			gate_edges_reg <= 3'h0;
		end else if (slow_edge) begin
			gate_edges_reg <= gate_edges_reg + 3'h1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_gate_four;
		$fell(gate_reg) |-> gate_edges_reg == SLOW_PERIODS;
	endproperty
	a_gate_four: assert property (p_gate_four) else $error("gate not four slow periods"); // [RQ2]

	property p_fast_store;
		conv_end && task_reg == TK_FAST_CAL |=> fast_val_reg == $past(conv_result_i) && upd_reg;
	endproperty
	a_fast_store: assert property (p_fast_store) else $error("fast value not stored"); // [RQ3]

	property p_osc_off;
		state_reg == S_IDLE |-> !fast_osc_en_o;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("fast oscillator on while idle"); // [RQ4]

	property p_ring_cal;
		conv_start_o |-> ring_cal_o && fast_osc_en_o;
	endproperty
	a_ring_cal: assert property (p_ring_cal) else $error("start without ring cal"); // [RQ16]

	property p_amp_up_cell;
		conv_end && task_reg == TK_AMP_UP |=> ram_wr_o.we && ram_wr_o.addr == RAM_AMP_UP;
	endproperty
	a_amp_up_cell: assert property (p_amp_up_cell) else $error("upstream cell wrong"); // [RQ11]

	property p_ref_low_cell;
		conv_end && task_reg == TK_REF_HALF |=> ram_wr_o.addr == RAM_CAL_LOW && !ref_half_o;
	endproperty
	a_ref_low_cell: assert property (p_ref_low_cell) else $error("low ref cell wrong"); // [RQ12]

	property p_zcl_over;
		conv_end && task_reg == TK_OFFSET |=> zero_cross_level_o == $past(conv_result_i.frac[7:0]);
	endproperty
	a_zcl_over: assert property (p_zcl_over) else $error("zero-cross not overwritten"); // [RQ15]

	property p_rate_off;
		state_reg == S_IDLE && trig_edge && cpc_reg[FAST_RATE_LSB +: RATE_W] == 3'h0
			|=> !due_reg[TK_FAST_CAL];
	endproperty
	a_rate_off: assert property (p_rate_off) else $error("rate zero task due"); // [RQ19]

	property p_peak_win;
		peak_hold_o |-> peak_stop_wave_o != 5'h00 && peak_start_wave_o == PEAK_START_WAVE;
	endproperty
	a_peak_win: assert property (p_peak_win) else $error("peak window wrong"); // [RQ9]

	property p_done_last;
		tasks_done_o |-> due_reg == '0 && !fast_osc_en_o;
	endproperty
	a_done_last: assert property (p_done_last) else $error("handover before tasks"); // [RQ20]

	c_fast_cal: cover property (conv_end && task_reg == TK_FAST_CAL);
	c_amp_cal:  cover property (conv_end && task_reg == TK_REF_HALF);
	c_boot_zcc: cover property (conv_end && task_reg == TK_OFFSET ##[1:200] tasks_done_o);
	c_handover: cover property (tasks_done_o);

endmodule : ccs_top
`default_nettype wire

// [verification/ccs_fe_model.sv]
// Converter, peak detector and slow oscillator stand-in for the scheduler bench
`default_nettype none
module ccs_fe_model
	import ccs_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      conv_start_i,
	input  wire ccs_task_e task_i,
	input  wire logic      peak_hold_i,
	input  wire logic      gate_i,
	output logic           slow_osc_o,
	output logic           peak_done_o,
	output logic           conv_done_o,
	output ccs_raw_s       result_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cyc;
	int          left;
	logic [2:0]  t;
	logic        gate_prev;
	// Quiet start
	initial begin
		gate_prev = 1'b0;
		cyc = 0;
		left = -1;
		t = 3'h0;
		slow_osc_o = 1'b0;
		peak_done_o = 1'b0;
		conv_done_o = 1'b0;
		result_o = 32'h0;
	end
	// Slow clock of 16 cycles; odd tasks convert slowly, even ones promptly
	// Fast calibration answers only once its gate has closed
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		gate_prev <= gate_i;
		slow_osc_o <= cyc[3];
		peak_done_o <= peak_hold_i;
		conv_done_o <= (left == 0);
		left <= (left > 0) ? left - 1 : -1;
		result_o <= ~result_o; // Bus carries junk between answers
		if (left == 0) begin
			result_o <= {16'h01E8, 8'hC3, 5'h15, t}; // Whole periods high, fraction low
		end
		if (gate_prev === 1'b1 && gate_i === 1'b0) begin
			left <= 2;
		end
		if (conv_start_i === 1'b1) begin
			t <= task_i;
			left <= (task_i == TK_FAST_CAL) ? -1 : (task_i[0] ? 20 : 2);
		end
	end
endmodule : ccs_fe_model
`default_nettype wire

// [verification/ccs_top_tb_top.sv]
// Self-checking bench for the calibration scheduler
`default_nettype none
module ccs_top_tb_top
	import ccs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_CPC = {IDX_CLOCK_POWER_CONFIG, 2'h0};
	localparam logic [11:0] A_FRC = {IDX_FRONTEND_RATE_CONFIG, 2'h0};
	localparam logic [11:0] A_AMC = {IDX_AMPLITUDE_MEAS_CONFIG, 2'h0};
	localparam logic [11:0] A_ZCL = {IDX_ZERO_CROSS_LEVEL, 2'h0};
	localparam logic [11:0] A_FCV = {IDX_FAST_CLOCK_CAL_VALUE, 2'h0};
	localparam logic [11:0] A_STA = {IDX_CAL_STATUS, 2'h0};
	logic        clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
	logic        seq_trig_i = 0, wb_ack_o, slow_osc_i, peak_done_i, conv_done_i;
	logic        fast_osc_en_o, conv_start_o, ring_cal_o, conv_gate_o, peak_hold_o;
	logic        discharge_o, ref_half_o, fast_clock_cal_updated_o, tasks_done_o;
	logic [11:0] wb_adr_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
	logic [3:0]  wb_sel_i = 0;
	logic [4:0]  peak_start_wave_o, peak_stop_wave_o;
	logic [7:0]  zero_cross_level_o;
	ccs_task_e   conv_task_o;
	ccs_raw_s    conv_result_i;
	ccs_ram_wr_s ram_wr_o;
	int          errors = 0, checks_done = 0, cycles = 0;
	int          fast_runs = 0, off_runs = 0, gate_len = 0;
	logic [8:0]  ram_q[$];
	logic [31:0] ramd_q[$];
	logic [8:0]  ea[4] = '{9'h082, 9'h086, 9'h083, 9'h087};
	ccs_top ccs_top_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
		.wb_stb_i, .wb_dat_o, .wb_ack_o, .seq_trig_i, .slow_osc_i, .peak_done_i, .conv_done_i,
		.conv_result_i, .fast_osc_en_o, .conv_start_o, .ring_cal_o, .conv_task_o, .conv_gate_o,
		.peak_hold_o, .peak_start_wave_o, .peak_stop_wave_o, .discharge_o, .ref_half_o,
		.ram_wr_o, .zero_cross_level_o, .fast_clock_cal_updated_o, .tasks_done_o);
	ccs_fe_model ccs_fe_model_i (.clk_i(clk_i), .conv_start_i(conv_start_o),
		.task_i(conv_task_o), .peak_hold_i(peak_hold_o), .gate_i(conv_gate_o),
		.slow_osc_o(slow_osc_i), .peak_done_o(peak_done_i), .conv_done_o(conv_done_i),
		.result_o(conv_result_i));
	always #2.5 clk_i = ~clk_i;
	task automatic stop_test();
		if (errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One classic Wishbone cycle, held until ack
	task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk
	// Wait for the task list to finish, then the oscillator must be off
	task automatic wait_done();
		do @(posedge clk_i); while (tasks_done_o !== 1'b1);
		@(posedge clk_i);
		chk(fast_osc_en_o, 32'h0);
	endtask : wait_done
	task automatic trig();
		seq_trig_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		seq_trig_i <= 1'b0;
		wait_done();
	endtask : trig
	// Watch the converter link and cut a hang short
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			stop_test();
		end
		if (ram_wr_o.we === 1'b1) begin
			ram_q.push_back(ram_wr_o.addr);
			ramd_q.push_back(ram_wr_o.data);
		end
		if (conv_gate_o === 1'b1) gate_len++;
		if (conv_start_o === 1'b1) begin
			chk(ring_cal_o, 32'h1);
			chk(fast_osc_en_o, 32'h1);
			chk(peak_hold_o, 32'h0);
			chk(discharge_o, conv_task_o inside {[TK_AMP_UP:TK_REF_HALF]});
			chk(ref_half_o, conv_task_o === TK_REF_HALF);
			if (conv_task_o === TK_FAST_CAL) fast_runs++;
			if (conv_task_o === TK_OFFSET) off_runs++;
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_done();
		chk(off_runs, 1);
		chk(zero_cross_level_o, 32'hA8);
		wb(1'b1, A_ZCL, 32'h55);
		rchk(A_ZCL, 32'h55);
		rchk(12'h800, 32'h0);
		wb(1'b1, A_CPC, 32'h1);
		wb(1'b1, A_FRC, 32'h1);
		wb(1'b1, A_AMC, 32'h1051);
		rchk(A_AMC, 32'h1051);
		gate_len = 0;
		trig();
		chk(ram_q.size(), 4);
		foreach (ea[i]) begin
			chk(ram_q[i], ea[i]);
			chk(ramd_q[i], {16'h01E8, 8'hC3, 5'h15, 3'(i + 2)});
		end
		chk(gate_len, 64);
		chk(zero_cross_level_o, 32'hA8);
		chk(peak_stop_wave_o, 32'h5);
		chk(peak_start_wave_o, 32'h1);
		chk(fast_clock_cal_updated_o, 32'h1);
		rchk(A_STA, 32'h1);
		rchk(A_FCV, 32'h01E8C3A9);
		rchk(A_STA, 32'h0);
		chk(fast_clock_cal_updated_o, 32'h0);
		wb(1'b1, A_FCV, 32'h0);
		rchk(A_FCV, 32'h01E8C3A9);
		wb(1'b1, A_CPC, 32'h3);
		wb(1'b1, A_FRC, 32'h0);
		wb(1'b1, A_AMC, 32'h0);
		fast_runs = 0;
		ram_q.delete();
		repeat (10) trig();
		chk(fast_runs, 2);
		chk(ram_q.size(), 0);
		wb(1'b1, A_CPC, 32'h0);
		fast_runs = 0;
		repeat (2) trig();
		chk(fast_runs, 0);
		stop_test();
	end
endmodule : ccs_top_tb_top
`default_nettype wire
